// ---- lts_grabber.sv ----
// Frame grabber model: captures each video line, drives the line trigger.
// Assumes the block changes its outputs only on rising clock edges.
`timescale 1ns/1ps
module lts_grabber
   import lts_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [PIX_W-1:0] pix,
   input wire logic lv,
   input wire logic dv,
   output logic trig
);
   logic [PIX_W-1:0] cap [0:63];
   int n, len, lines, dv_bad;
   logic lv_q;
   initial trig = 1'b0;
   // Full low-high-low cycle, so each call is one fresh rising edge
   task automatic fire();
      trig <= 1'b1;
      repeat (4) @(posedge clk);
      trig <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         n <= 0;
         len <= 0;
         lines <= 0;
         dv_bad <= 0;
         lv_q <= 1'b0;
      end else begin
         lv_q <= lv;
         if (dv !== lv) dv_bad <= dv_bad + 1;
         if (lv === 1'b1) begin
            if (n < 64) cap[n] <= pix;
            n <= n + 1;
         end else if (lv_q) begin
            len <= n;
            n <= 0;
            lines <= lines + 1;
         end
      end
   end
endmodule

// ---- lts_line_stamp.sv ----
// Line sequencer: test patterns, sensor pass-through, stamp, APB registers.
// Assumes an APB master on CLK_SYS and an asynchronous line trigger pin.
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
// Operation
// - With a pattern selected, output comes from internal logic, sensor ignored.
// - Mode field selects none or one of four patterns.
// - Each trigger transition cycle yields one line; far side toggles it.
// - Free-run: one line per internal line period.
// - Exposure setting never alters pattern timing or content.
// - Fixed gradient 8-bit: odd pixels up from 0, even down from 255.
// - Fixed gradient spans 0..1023 at 10 bit, 0..4095 at 12 bit.
// - Moving gradient: pixel 1 is 0, rising by one, period 256.
// - Moving gradient advances by one per line.
// - Black pattern is zero in all depths.
// - Gray pattern is 127, 511 or 2047 by depth.
// - Stamp enabled: 16 stamp pixels follow the last image pixel.
// - Stamp bytes sit in the upper 8 bits, low bits zero.
// - Stamp follows the last window pixel with no gap.
// - Line and data valid stay high over window and stamp pixels.
// - Stamp 1 is AA; stamp 2 is 57 for line B in dual mode, else 55.
// - Stamps 3-4 hold line counter, wraps, cleared while stamp off.
// - Stamps 5-7 hold window pixel sum, low byte first.
// - Stamps 9-10 hold count of pixels above high threshold.
module lts_line_stamp
   import lts_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RSTN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic EXT_LINE_TRIGGER,
   input wire logic [PIX_W-1:0] SENS_PIX,
   input wire logic SENS_LINE_B,
   output logic [PIX_W-1:0] PIX_OUT,
   output logic LINE_VALID,
   output logic DATA_VALID
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_IMAGE = 3'b010,
      ST_STAMP = 3'b100
   } lts_state_type;

   lts_pat_if pat ();
   lts_pattern u_pattern (.pat(pat));

   lts_state_type st_reg;
   lts_pat_type mode_reg;
   lts_depth_type depth_reg;
   logic stamp_en_reg, free_run_reg, dual_reg;
   logic [POS_W-1:0] win_start_reg, win_len_reg, idx_reg;
   logic [31:0] period_reg, fr_cnt_reg, exposure_reg;
   logic [PIX_W-1:0] high_thr_reg, pix_out_reg;
   logic [3:0] sidx_reg;
   logic [7:0] shift_reg;
   logic [15:0] line_cnt_reg, high_cnt_reg;
   logic [23:0] sum_reg;
   logic line_b_reg, ovr_reg, lv_reg;
   logic pready_reg, pslverr_reg;
   logic [31:0] prdata_reg;
   logic trig_s1_reg, trig_s2_reg, trig_s3_reg, trig_lvl_reg, trig_prev_reg;

   logic apb_take, apb_done, wr_en, hit, line_req, line_start;
   logic img_last, stamp_last;
   logic [31:0] rd_data;
   logic [PIX_W-1:0] img_val, stamp_val;
   logic [7:0] stamp_byte;

   // Stamp byte placed in the upper eight bits of the output word
   function automatic logic [PIX_W-1:0] stamp_scale(input logic [7:0] b,
      input lts_depth_type d);
      logic [PIX_W-1:0] r;
      r = {4'h0, b};
      unique case (d)
         DEP_10: r = {2'h0, b, 2'h0};
         DEP_12: r = {b, 4'h0};
         default: r = {4'h0, b};
      endcase
      return r;
   endfunction

   // APB: two-cycle access, pready raised one cycle into the access phase
   always_comb begin
      apb_take = PSEL && PENABLE && !pready_reg;
      apb_done = PSEL && PENABLE && pready_reg;
      wr_en = apb_done && PWRITE;
      hit = 1'b1;
      rd_data = '0;
      unique case (PADDR)
         OFF_CTRL: begin
            rd_data[CTRL_MODE_LSB +: 3] = mode_reg;
            rd_data[CTRL_DEPTH_LSB +: 2] = depth_reg;
            rd_data[CTRL_STAMP_BIT] = stamp_en_reg;
            rd_data[CTRL_FREE_BIT] = free_run_reg;
            rd_data[CTRL_DUAL_BIT] = dual_reg;
         end
         OFF_WIN_START: rd_data[POS_W-1:0] = win_start_reg;
         OFF_WIN_LEN: rd_data[POS_W-1:0] = win_len_reg;
         OFF_PERIOD: rd_data = period_reg;
         OFF_EXPOSURE: rd_data = exposure_reg;
         OFF_HIGH_THR: rd_data[PIX_W-1:0] = high_thr_reg;
         OFF_STATUS: begin
            rd_data[15:0] = line_cnt_reg;
            rd_data[STAT_OVR_BIT] = ovr_reg;
            rd_data[STAT_BUSY_BIT] = (st_reg != ST_IDLE);
         end
         default: hit = 1'b0;
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= '0;
      end else begin
         pready_reg <= apb_take;
         pslverr_reg <= apb_take && !hit;
         prdata_reg <= (apb_take && !PWRITE) ? rd_data : '0;
      end
   end

   // Control fields; an unknown mode falls back to sensor pass-through
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         mode_reg <= PAT_NONE;
         depth_reg <= DEP_8;
         stamp_en_reg <= 1'b0;
         free_run_reg <= 1'b0;
         dual_reg <= 1'b0;
         win_start_reg <= WIN_START_RST;
         win_len_reg <= WIN_LEN_RST;
         period_reg <= PERIOD_RST;
         exposure_reg <= '0;
         high_thr_reg <= HIGH_THR_RST;
      end else if (wr_en) begin
         unique case (PADDR)
            OFF_CTRL: begin
               mode_reg <= (PWDATA[CTRL_MODE_LSB +: 3] > PAT_GRAY) ?
                  PAT_NONE : lts_pat_type'(PWDATA[CTRL_MODE_LSB +: 3]);
               depth_reg <= (PWDATA[CTRL_DEPTH_LSB +: 2] > DEP_12) ?
                  DEP_8 : lts_depth_type'(PWDATA[CTRL_DEPTH_LSB +: 2]);
               stamp_en_reg <= PWDATA[CTRL_STAMP_BIT];
               free_run_reg <= PWDATA[CTRL_FREE_BIT];
               dual_reg <= PWDATA[CTRL_DUAL_BIT];
            end
            OFF_WIN_START: win_start_reg <= PWDATA[POS_W-1:0];
            OFF_WIN_LEN: win_len_reg <= PWDATA[POS_W-1:0];
            OFF_PERIOD: period_reg <= PWDATA;
            // Kept for software only; line timing never reads it
            OFF_EXPOSURE: exposure_reg <= PWDATA;
            OFF_HIGH_THR: high_thr_reg <= PWDATA[PIX_W-1:0];
            default: ;
         endcase
      end
   end

   // Trigger pin: three flops, level accepted once stages two and three agree
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         trig_s1_reg <= 1'b0;
         trig_s2_reg <= 1'b0;
         trig_s3_reg <= 1'b0;
         trig_lvl_reg <= 1'b0;
         trig_prev_reg <= 1'b0;
      end else begin
         trig_s1_reg <= EXT_LINE_TRIGGER;
         trig_s2_reg <= trig_s1_reg;
         trig_s3_reg <= trig_s2_reg;
         if (trig_s2_reg == trig_s3_reg) begin
            trig_lvl_reg <= trig_s3_reg;
         end
         trig_prev_reg <= trig_lvl_reg;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         fr_cnt_reg <= '0;
      end else if (!free_run_reg || fr_cnt_reg == '0) begin
         fr_cnt_reg <= period_reg - 32'h0000_0001;
      end else begin
         fr_cnt_reg <= fr_cnt_reg - 32'h0000_0001;
      end
   end

   always_comb begin
      line_req = free_run_reg ? (fr_cnt_reg == '0)
         : (trig_lvl_reg && !trig_prev_reg);
      line_start = line_req && st_reg == ST_IDLE && win_len_reg != '0;
      img_last = idx_reg == win_len_reg - 16'h0001;
      stamp_last = sidx_reg == 4'(STAMP_LEN - 1);
   end

   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         st_reg <= ST_IDLE;
         idx_reg <= '0;
         sidx_reg <= '0;
         line_b_reg <= 1'b0;
      end else begin
         unique case (st_reg)
            ST_IDLE: if (line_start) begin
               st_reg <= ST_IMAGE;
               idx_reg <= '0;
               line_b_reg <= SENS_LINE_B;
            end
            ST_IMAGE: begin
               idx_reg <= idx_reg + 16'h0001;
               sidx_reg <= '0;
               if (img_last) begin
                  st_reg <= stamp_en_reg ? ST_STAMP : ST_IDLE;
               end
            end
            ST_STAMP: begin
               sidx_reg <= sidx_reg + 4'h1;
               if (stamp_last) begin
                  st_reg <= ST_IDLE;
               end
            end
            default: st_reg <= ST_IDLE;
         endcase
      end
   end

   // A request that finds a line in flight is dropped; set beats clear
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         ovr_reg <= 1'b0;
      end else if (line_req && st_reg != ST_IDLE) begin
         ovr_reg <= 1'b1;
      end else if (wr_en && PADDR == OFF_STATUS && PWDATA[STAT_OVR_BIT]) begin
         ovr_reg <= 1'b0;
      end
   end

   always_comb begin
      pat.mode = mode_reg;
      pat.depth = depth_reg;
      pat.pix_num = win_start_reg + idx_reg;
      pat.shift = shift_reg;
      img_val = (mode_reg == PAT_NONE) ? SENS_PIX : pat.value;
   end

   always_comb begin
      stamp_byte = STAMP_RSVD;
      unique case (sidx_reg)
         4'h0: stamp_byte = SYNC_A;
         4'h1: stamp_byte = (dual_reg && line_b_reg) ?
            SYNC_B_LINEB : SYNC_B_NORM;
         4'h2: stamp_byte = line_cnt_reg[7:0];
         4'h3: stamp_byte = line_cnt_reg[15:8];
         4'h4: stamp_byte = sum_reg[7:0];
         4'h5: stamp_byte = sum_reg[15:8];
         4'h6: stamp_byte = sum_reg[23:16];
         4'h8: stamp_byte = high_cnt_reg[7:0];
         4'h9: stamp_byte = high_cnt_reg[15:8];
         default: stamp_byte = STAMP_RSVD;
      endcase
      stamp_val = stamp_scale(stamp_byte, depth_reg);
   end

   // Statistics cover window pixels only; frozen while stamp pixels go out
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         sum_reg <= '0;
         high_cnt_reg <= '0;
      end else if (line_start) begin
         sum_reg <= '0;
         high_cnt_reg <= '0;
      end else if (st_reg == ST_IMAGE) begin
         sum_reg <= sum_reg + 24'(img_val);
         if (img_val > high_thr_reg) begin
            high_cnt_reg <= high_cnt_reg + 16'h0001;
         end
      end
   end

   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         line_cnt_reg <= '0;
      end else if (!stamp_en_reg) begin
         line_cnt_reg <= '0;
      end else if (st_reg == ST_STAMP && stamp_last) begin
         line_cnt_reg <= line_cnt_reg + 16'h0001;
      end
   end

   // Gradient restarts at zero whenever the moving pattern is not selected
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         shift_reg <= '0;
      end else if (mode_reg != PAT_MOVING) begin
         shift_reg <= '0;
      end else if (st_reg != ST_IDLE && line_start == 1'b0 &&
            ((st_reg == ST_IMAGE && img_last && !stamp_en_reg) ||
            (st_reg == ST_STAMP && stamp_last))) begin
         shift_reg <= shift_reg + 8'h01;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         pix_out_reg <= '0;
         lv_reg <= 1'b0;
      end else begin
         lv_reg <= st_reg != ST_IDLE;
         pix_out_reg <= (st_reg == ST_IMAGE) ? img_val :
            (st_reg == ST_STAMP) ? stamp_val : '0;
      end
   end

   assign PRDATA = prdata_reg;
   assign PREADY = pready_reg;
   assign PSLVERR = pslverr_reg;
   assign PIX_OUT = pix_out_reg;
   assign LINE_VALID = lv_reg;
   assign DATA_VALID = lv_reg;

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RSTN);

   sequence s_img_end;
      st_reg == ST_IMAGE && img_last && stamp_en_reg;
   endsequence
   sequence s_stamp_begin;
      st_reg == ST_STAMP && sidx_reg == 4'h0;
   endsequence

   property p_mode_legal;
      mode_reg inside {PAT_NONE, PAT_FIXED, PAT_MOVING, PAT_BLACK, PAT_GRAY};
   endproperty
   a_mode_legal: assert property (p_mode_legal)
      else $error("pattern mode out of range");

   property p_black;
      st_reg == ST_IMAGE && mode_reg == PAT_BLACK |=> PIX_OUT == '0;
   endproperty
   a_black: assert property (p_black)
      else $error("black pattern pixel not zero");

   property p_gray8;
      st_reg == ST_IMAGE && mode_reg == PAT_GRAY && depth_reg == DEP_8
         |=> PIX_OUT == GRAY_8;
   endproperty
   a_gray8: assert property (p_gray8)
      else $error("gray pattern pixel wrong");

   property p_fixed_pix2;
      st_reg == ST_IMAGE && mode_reg == PAT_FIXED && depth_reg == DEP_8 &&
         pat.pix_num[8:0] == 9'h002 |=> PIX_OUT == 12'h0FF;
   endproperty
   a_fixed_pix2: assert property (p_fixed_pix2)
      else $error("fixed gradient pixel two not 255");

   property p_no_gap;
      s_img_end |=> s_stamp_begin;
   endproperty
   a_no_gap: assert property (p_no_gap)
      else $error("stamp does not follow last window pixel");

   property p_sync_a;
      s_stamp_begin ##0 depth_reg == DEP_8 |=> PIX_OUT == {4'h0, SYNC_A};
   endproperty
   a_sync_a: assert property (p_sync_a)
      else $error("first stamp pixel wrong");

   property p_stamp_len;
      st_reg == ST_STAMP && stamp_last |=> st_reg == ST_IDLE;
   endproperty
   a_stamp_len: assert property (p_stamp_len)
      else $error("stamp length not sixteen");

   property p_valid;
      st_reg != ST_IDLE |=> LINE_VALID && DATA_VALID;
   endproperty
   a_valid: assert property (p_valid)
      else $error("valid low during line");

   property p_cnt_clear;
      !stamp_en_reg |=> line_cnt_reg == '0;
   endproperty
   a_cnt_clear: assert property (p_cnt_clear)
      else $error("line counter not cleared");

   property p_shift;
      $rose(st_reg == ST_IDLE) && $past(mode_reg) == PAT_MOVING
         |-> shift_reg == $past(shift_reg) + 8'h01;
   endproperty
   a_shift: assert property (p_shift)
      else $error("moving gradient did not advance");
endmodule

// ---- lts_line_stamp_test.sv ----
// Self-checking bench: APB register tasks, captured lines compared.
// Assumes the grabber model sits on the video side of the block.
`timescale 1ns/1ps
module lts_line_stamp_test;
   import lts_pkg::*;
   logic clk_sys, rstn, psel, penable, pwrite, pready, pslverr, err;
   logic sens_b, lv, dv, trig;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [PIX_W-1:0] sens_pix, pix;
   int mismatches, check_count, cycles, l0;

   lts_line_stamp i_dut (.CLK_SYS(clk_sys), .RSTN(rstn), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .EXT_LINE_TRIGGER(trig), .SENS_PIX(sens_pix), .SENS_LINE_B(sens_b),
      .PIX_OUT(pix), .LINE_VALID(lv), .DATA_VALID(dv));
   lts_grabber i_grab (.clk(clk_sys), .rstn(rstn), .pix(pix), .lv(lv),
      .dv(dv), .trig(trig));

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   task automatic conclude();
      $display("Checks %0d, mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         conclude();
      end
   end

   task automatic check(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   // Waits on PREADY without a limit; the cycle ceiling ends a hang
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic ctrl(int m, int d, int s, int f, int du);
      apb(1'b1, OFF_CTRL, 32'(m | d << 4 | s << 8 | f << 9 | du << 10));
   endtask

   task automatic line();
      int n0;
      n0 = i_grab.lines;
      i_grab.fire();
      while (i_grab.lines == n0) @(posedge clk_sys);
      repeat (4) @(posedge clk_sys);
   endtask

   function automatic logic [11:0] ep(int m, int d, int n, int sh);
      logic [7:0] v;
      int k;
      k = (n - 1) % 512;
      v = (k % 2 == 0) ? 8'(k / 2) : 8'(255 - (k - 1) / 2);
      if (m == 2) v = 8'((n - 1 + sh) % 256);
      if (m == 0) return 12'h5A3;
      if (m == 3) return 12'h000;
      if (m == 4) return d == 0 ? 12'h07F : d == 1 ? 12'h1FF : 12'h7FF;
      if (d == 1) return {2'h0, v, v[7:6]};
      if (d == 2) return {v, v[7:4]};
      return {4'h0, v};
   endfunction

   task automatic chk(int m, int d, int st, int ln, int sh);
      check(32'(i_grab.len), 32'(ln));
      for (int i = 0; i < ln; i++)
         check(32'(i_grab.cap[i]), 32'(ep(m, d, st + i, sh)));
   endtask

   task automatic chk_stamp(int d, logic [7:0] b1, logic [15:0] cnt,
      logic [23:0] sum, logic [15:0] hi);
      logic [7:0] b [0:15];
      logic [11:0] e;
      b = '{8'hAA, b1, cnt[7:0], cnt[15:8], sum[7:0], sum[15:8],
         sum[23:16], 8'h00, hi[7:0], hi[15:8], 8'h00, 8'h00, 8'h00,
         8'h00, 8'h00, 8'h00};
      check(32'(i_grab.len), 32'h20);
      for (int k = 0; k < 16; k++) begin
         e = d == 0 ? {4'h0, b[k]} : d == 1 ? {2'h0, b[k], 2'h0}
            : {b[k], 4'h0};
         check(32'(i_grab.cap[16 + k]), 32'(e));
      end
   endtask

   initial begin
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      sens_pix = 12'h5A3;
      sens_b = 1'b0;
      repeat (5) @(posedge clk_sys);
      rstn <= 1'b1;
      @(posedge clk_sys);
      apb(1'b0, OFF_WIN_START, 0);
      check(rd, 32'h1);
      apb(1'b0, OFF_WIN_LEN, 0);
      check(rd, 32'h1000);
      apb(1'b0, OFF_PERIOD, 0);
      check(rd, 32'h2000);
      apb(1'b0, OFF_HIGH_THR, 0);
      check(rd, 32'hC8);
      apb(1'b0, 8'h1C, 0);
      check({rd[30:0], err}, 32'h1);
      apb(1'b1, OFF_WIN_LEN, 16);
      // Starts 250 and 505 cover the 256/257 and 511..514 seams
      for (int s = 0; s < 2; s++) begin
         apb(1'b1, OFF_WIN_START, s ? 505 : 250);
         for (int d = 0; d < 3; d++) begin
            ctrl(1, d, 0, 0, 0);
            line();
            chk(1, d, s ? 505 : 250, 16, 0);
         end
      end
      ctrl(2, 0, 0, 0, 0);
      for (int j = 0; j < 3; j++) begin
         line();
         chk(2, 0, 505, 16, j);
      end
      for (int m = 3; m < 5; m++)
         for (int d = 0; d < 3; d++) begin
            ctrl(m, d, 0, 0, 0);
            line();
            chk(m, d, 250, 16, 0);
         end
      ctrl(0, 2, 0, 0, 0);
      line();
      chk(0, 2, 250, 16, 0);
      apb(1'b1, OFF_HIGH_THR, 126);
      ctrl(4, 0, 1, 0, 0);
      line();
      chk_stamp(0, 8'h55, 0, 24'h7F0, 16);
      apb(1'b1, OFF_HIGH_THR, 127);
      line();
      chk_stamp(0, 8'h55, 1, 24'h7F0, 0);
      sens_b <= 1'b1;
      ctrl(4, 2, 1, 0, 1);
      line();
      chk_stamp(2, 8'h57, 2, 24'h7FF0, 16);
      ctrl(4, 1, 0, 0, 1);
      ctrl(4, 1, 1, 0, 1);
      line();
      chk_stamp(1, 8'h57, 0, 24'h1FF0, 16);
      apb(1'b0, OFF_STATUS, 0);
      check({16'h0, rd[15:0]}, 32'h1);
      apb(1'b1, OFF_EXPOSURE, 32'hFFFF_FFFF);
      apb(1'b1, OFF_PERIOD, 64);
      ctrl(4, 0, 0, 1, 0);
      l0 = i_grab.lines;
      repeat (640) @(posedge clk_sys);
      ctrl(4, 0, 0, 0, 0);
      l0 = i_grab.lines - l0;
      check(32'(l0 >= 9 && l0 <= 11), 32'h1);
      repeat (100) @(posedge clk_sys);
      chk(4, 0, 250, 16, 0);
      check(32'(i_grab.dv_bad), 32'h0);
      conclude();
   end
endmodule

// ---- lts_pat_if.sv ----
// Carrier between the line sequencer and the test pattern generator.
// Assumes both ends sit on the same clock; the generator is combinational.
`timescale 1ns/1ps
interface lts_pat_if;
   import lts_pkg::*;
   lts_pat_type mode;
   lts_depth_type depth;
   logic [POS_W-1:0] pix_num;
   logic [7:0] shift;
   logic [PIX_W-1:0] value;
   modport gen (input mode, input depth, input pix_num, input shift,
      output value);
   modport user (output mode, output depth, output pix_num, output shift,
      input value);
endinterface

// ---- lts_pattern.sv ----
// Test pattern value generator: one pixel value per absolute pixel number.
// Assumes pixel numbers start at 1 and the caller registers the result.
`timescale 1ns/1ps
module lts_pattern
   import lts_pkg::*;
(
   lts_pat_if.gen pat
);
   // Widens an 8-bit gradient so that 0 and 255 hit both range ends
   function automatic logic [PIX_W-1:0] widen(input logic [7:0] v,
      input lts_depth_type d);
      logic [PIX_W-1:0] r;
      r = {4'h0, v};
      unique case (d)
         DEP_10: r = {2'h0, v, v[7:6]};
         DEP_12: r = {v, v[7:4]};
         default: r = {4'h0, v};
      endcase
      return r;
   endfunction

   logic [8:0] fix_pos;
   logic [7:0] fix_val;
   logic [7:0] mov_val;

   always_comb begin
      fix_pos = 9'(pat.pix_num - 16'h0001);
      // Odd pixels climb, even pixels fall, period 512
      fix_val = fix_pos[0] ? ~fix_pos[8:1] : fix_pos[8:1];
      mov_val = 8'(pat.pix_num - 16'h0001) + pat.shift;
   end

   always_comb begin
      pat.value = '0;
      unique case (pat.mode)
         PAT_FIXED: pat.value = widen(fix_val, pat.depth);
         PAT_MOVING: pat.value = widen(mov_val, pat.depth);
         PAT_BLACK: pat.value = '0;
         PAT_GRAY: begin
            unique case (pat.depth)
               DEP_10: pat.value = GRAY_10;
               DEP_12: pat.value = GRAY_12;
               default: pat.value = GRAY_8;
            endcase
         end
         default: pat.value = '0;
      endcase
   end
endmodule

// ---- lts_pkg.sv ----
// Shared constants and types for the line test pattern and stamp block.
// Assumes a 32-bit APB register bus and a 12-bit pixel output path.
package lts_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned PIX_W = 12;
   localparam int unsigned POS_W = 16;
   localparam int unsigned STAMP_LEN = 16;

   localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_WIN_START = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_WIN_LEN = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_PERIOD = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_EXPOSURE = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_HIGH_THR = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h18;

   localparam int unsigned CTRL_MODE_LSB = 0;
   localparam int unsigned CTRL_DEPTH_LSB = 4;
   localparam int unsigned CTRL_STAMP_BIT = 8;
   localparam int unsigned CTRL_FREE_BIT = 9;
   localparam int unsigned CTRL_DUAL_BIT = 10;
   localparam int unsigned STAT_OVR_BIT = 16;
   localparam int unsigned STAT_BUSY_BIT = 17;

   localparam logic [POS_W-1:0] WIN_START_RST = 16'h0001;
   localparam logic [POS_W-1:0] WIN_LEN_RST = 16'h1000;
   localparam logic [31:0] PERIOD_RST = 32'h0000_2000;
   localparam logic [PIX_W-1:0] HIGH_THR_RST = 12'h0C8;

   typedef enum logic [2:0] {
      PAT_NONE = 3'h0,
      PAT_FIXED = 3'h1,
      PAT_MOVING = 3'h2,
      PAT_BLACK = 3'h3,
      PAT_GRAY = 3'h4
   } lts_pat_type;

   typedef enum logic [1:0] {
      DEP_8 = 2'h0,
      DEP_10 = 2'h1,
      DEP_12 = 2'h2
   } lts_depth_type;

   localparam logic [PIX_W-1:0] GRAY_8 = 12'h07F;
   localparam logic [PIX_W-1:0] GRAY_10 = 12'h1FF;
   localparam logic [PIX_W-1:0] GRAY_12 = 12'h7FF;
   localparam logic [7:0] SYNC_A = 8'hAA;
   localparam logic [7:0] SYNC_B_NORM = 8'h55;
   localparam logic [7:0] SYNC_B_LINEB = 8'h57;
   localparam logic [7:0] STAMP_RSVD = 8'h00;
endpackage
